// ==== hdl/reclose_pkg.sv ====
// Purpose: constants for the reclose supervision block
// Assumes: 100 MHz clk, AHB-Lite register access
// Notes: delays held in milliseconds
package reclose_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LOCKDLY = 8'h04;
  localparam logic [7:0] A_DEBLKDLY = 8'h08;
  localparam logic [7:0] A_EXAM = 8'h0C;
  localparam logic [7:0] A_MANBLK = 8'h10;
  localparam logic [7:0] A_LIMITS = 8'h14;
  localparam logic [7:0] A_SVC1 = 8'h18;
  localparam logic [7:0] A_SVC2 = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_SHOTS = 8'h24;
  localparam logic [7:0] A_TOTAL = 8'h28;
  localparam logic [7:0] A_OUTCOME = 8'h2C;
  localparam logic [7:0] A_SVCCNT = 8'h30;
  localparam logic [7:0] A_IRQSTAT = 8'h34;
  localparam logic [7:0] A_IRQMASK = 8'h38;
  // control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_DISEL = 1;
  localparam int CMD_PANEL = 4;
  localparam int CMD_STAT = 5;
  localparam int CMD_SVC = 6;
  localparam int CMD_HOUR = 7;
  // event bits
  localparam int EV_SUCC = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_LOCK = 2;
  localparam int EV_PANEL = 3;
  localparam int EV_HOUR = 4;
  localparam int EV_ALM1 = 5;
  localparam int EV_ALM2 = 6;
  localparam int EV_EXCEED = 7;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] DLY_RST = 16'h0064;
  localparam logic [15:0] EXAM_RST = 16'h03E8;
  localparam logic [7:0] SHOTS_RST = 8'h02;
  localparam logic [7:0] PERHOUR_RST = 8'h0A;
  localparam logic [15:0] SVC1_RST = 16'h03E8;
  localparam logic [15:0] SVC2_RST = 16'h07D0;
  // timing
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int HOUR_MS = 3600000;
  // sequencer states
  typedef enum logic [2:0] {
    ST_READY = 3'b000,
    ST_WAITOPEN = 3'b001,
    ST_EXAMINE = 3'b010,
    ST_LOCKOUT = 3'b011,
    ST_RELEASE = 3'b100
  } seq_e;
endpackage : reclose_pkg

// ==== hdl/reclose_supervision_control.sv ====
// Purpose: reclose supervision: lockout, blocking, outcome, counters
// Assumes: pins asynchronous, AHB-Lite slave with zero wait states
// Notes: all delays in ms; shot, service and hourly counters saturate; statistics counters wrap
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module reclose_supervision_control
  import reclose_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES,
  parameter int HourMs = HOUR_MS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic externalBlockInA,
  input wire logic externalBlockInB,
  input wire logic externalShotAdvanceIn,
  input wire logic externalLockoutIn,
  input wire logic inputPinLockoutClearIn,
  input wire logic remoteLockoutClearIn,
  input wire logic [3:0] cycleAbortIn,
  input wire logic tripIn,
  input wire logic breakerClosedIn,
  input wire logic manualCloseIn,
  output logic closeCommand,
  output logic recloseRunning,
  output logic lockedOut,
  output logic recloseBlocked,
  output logic recloseSuccess,
  output logic recloseFailure,
  output logic serviceAlarmFirst,
  output logic serviceAlarmSecond,
  output logic hourlyShotLimitExceeded,
  output logic panelLockoutCleared,
  output logic hourlyShotCounterCleared,
  output logic irq
);
  // ---- pin synchronisers ----
  logic [12:0] pinRaw; // raw pins gathered
  logic [12:0] syncA; // first stage only
  logic [12:0] syncB; // usable samples
  logic [12:0] syncPrev; // for edge detect
  assign pinRaw = {manualCloseIn, breakerClosedIn, tripIn, cycleAbortIn,
    remoteLockoutClearIn, inputPinLockoutClearIn, externalLockoutIn,
    externalShotAdvanceIn, externalBlockInB, externalBlockInA};

  // two flops per pin, then one for edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 13'h0000;
      syncB <= 13'h0000;
      syncPrev <= 13'h0000;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  logic blockCond; // any block input
  logic shotAdvRise; // shot advance edge
  logic extLock; // lockout input level
  logic pinClrRise; // pin clear edge
  logic remClrRise; // remote clear edge
  logic abortAny; // any abort input
  logic tripLvl; // protection trip
  logic tripRise; // new trip
  logic cbClosed; // breaker closed
  logic manRise; // manual close edge
  assign blockCond = syncB[0] | syncB[1];
  assign shotAdvRise = syncB[2] & ~syncPrev[2];
  assign extLock = syncB[3];
  assign pinClrRise = syncB[4] & ~syncPrev[4];
  assign remClrRise = syncB[5] & ~syncPrev[5];
  assign abortAny = |syncB[9:6];
  assign tripLvl = syncB[10];
  assign tripRise = syncB[10] & ~syncPrev[10];
  assign cbClosed = syncB[11];
  assign manRise = syncB[12] & ~syncPrev[12];

  // ---- millisecond and hour ticks ----
  logic [31:0] msCnt, next_msCnt; // cycle prescaler
  logic [31:0] hourCnt, next_hourCnt; // ms within hour
  logic msTick; // one cycle per ms
  logic hourTick; // one cycle per hour
  assign msTick = (msCnt == 32'(MsCycles - 1));
  assign hourTick = msTick && (hourCnt == 32'(HourMs - 1));

  // next prescaler values
  always_comb begin
    next_msCnt = msTick ? 32'h00000000 : msCnt + 32'h00000001;
    next_hourCnt = hourCnt;
    if (hourTick) begin
      next_hourCnt = 32'h00000000;
    end else if (msTick) begin
      next_hourCnt = hourCnt + 32'h00000001;
    end
  end

  // prescaler registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msCnt <= 32'h00000000;
      hourCnt <= 32'h00000000;
    end else begin
      msCnt <= next_msCnt;
      hourCnt <= next_hourCnt;
    end
  end

  // ---- AHB-Lite slave and registers ----
  logic [1:0] ctrl, next_ctrl; // enable, pin-clear select
  logic [15:0] lockDly, next_lockDly; // lockout release ms
  logic [15:0] deblkDly, next_deblkDly; // deblock ms
  logic [15:0] examT, next_examT; // examination ms
  logic [15:0] manBlkT, next_manBlkT; // manual close block ms
  logic [7:0] maxShots, next_maxShots; // shots per cycle
  logic [7:0] maxPerHour, next_maxPerHour; // shots per hour
  logic [15:0] svc1, next_svc1; // alarm one limit
  logic [15:0] svc2, next_svc2; // alarm two limit
  logic [7:0] irqStat, next_irqStat; // sticky events
  logic [7:0] irqMask, next_irqMask; // event enables
  logic [3:0] cmd, next_cmd; // one-cycle commands
  logic [7:0] wrAddr, next_wrAddr; // data phase address
  logic wrPend, next_wrPend; // write data due
  logic [31:0] next_hrdata; // read data
  logic [7:0] events; // this cycle's events
  logic addrPhase; // valid transfer taken
  logic wrNow; // write data present
  // sequencer and counter state read back
  seq_e state, next_state;
  logic [7:0] shot, next_shot;
  logic [7:0] hourly, next_hourly;
  logic [15:0] total, next_total;
  logic [15:0] succCnt, next_succCnt;
  logic [15:0] failCnt, next_failCnt;
  logic [15:0] svcCnt, next_svcCnt;
  logic [15:0] manTimer, next_manTimer;
  logic [15:0] blkTimer, next_blkTimer;
  logic next_blocked;
  assign addrPhase = hsel && htrans[1] && hready;
  assign wrNow = wrPend;

  // bus decode, register writes, irq status
  always_comb begin
    next_wrPend = addrPhase && hwrite;
    next_wrAddr = addrPhase ? haddr[7:0] : wrAddr;
    next_ctrl = ctrl;
    next_lockDly = lockDly;
    next_deblkDly = deblkDly;
    next_examT = examT;
    next_manBlkT = manBlkT;
    next_maxShots = maxShots;
    next_maxPerHour = maxPerHour;
    next_svc1 = svc1;
    next_svc2 = svc2;
    next_irqMask = irqMask;
    next_cmd = 4'h0;
    next_irqStat = irqStat | events;
    if (wrNow) begin
      case (wrAddr)
        A_CTRL: begin
          next_ctrl = hwdata[1:0];
          next_cmd = hwdata[CMD_HOUR:CMD_PANEL];
        end
        A_LOCKDLY: next_lockDly = hwdata[15:0];
        A_DEBLKDLY: next_deblkDly = hwdata[15:0];
        A_EXAM: next_examT = hwdata[15:0];
        A_MANBLK: next_manBlkT = hwdata[15:0];
        A_LIMITS: begin
          next_maxShots = hwdata[7:0];
          next_maxPerHour = hwdata[15:8];
        end
        A_SVC1: next_svc1 = hwdata[15:0];
        A_SVC2: next_svc2 = hwdata[15:0];
        // new events win over the clear
        A_IRQSTAT: next_irqStat = (irqStat & ~hwdata[7:0]) | events;
        A_IRQMASK: next_irqMask = hwdata[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
    next_hrdata = 32'h00000000;
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        A_CTRL: next_hrdata = {30'h00000000, ctrl};
        A_LOCKDLY: next_hrdata = {16'h0000, lockDly};
        A_DEBLKDLY: next_hrdata = {16'h0000, deblkDly};
        A_EXAM: next_hrdata = {16'h0000, examT};
        A_MANBLK: next_hrdata = {16'h0000, manBlkT};
        A_LIMITS: next_hrdata = {16'h0000, maxPerHour, maxShots};
        A_SVC1: next_hrdata = {16'h0000, svc1};
        A_SVC2: next_hrdata = {16'h0000, svc2};
        A_STATUS: next_hrdata = {19'h00000, state, (manTimer != 16'h0000),
          hourlyShotLimitExceeded, serviceAlarmSecond, serviceAlarmFirst,
          recloseFailure, recloseSuccess, recloseBlocked, lockedOut,
          recloseRunning, irq};
        A_SHOTS: next_hrdata = {16'h0000, hourly, shot};
        A_TOTAL: next_hrdata = {16'h0000, total};
        A_OUTCOME: next_hrdata = {failCnt, succCnt};
        A_SVCCNT: next_hrdata = {16'h0000, svcCnt};
        A_IRQSTAT: next_hrdata = {24'h000000, irqStat};
        A_IRQMASK: next_hrdata = {24'h000000, irqMask};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // bus and register flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl <= CTRL_RST;
      lockDly <= DLY_RST;
      deblkDly <= DLY_RST;
      examT <= EXAM_RST;
      manBlkT <= DLY_RST;
      maxShots <= SHOTS_RST;
      maxPerHour <= PERHOUR_RST;
      svc1 <= SVC1_RST;
      svc2 <= SVC2_RST;
      irqStat <= 8'h00;
      irqMask <= 8'h00;
      cmd <= 4'h0;
      irq <= 1'b0;
    end else begin
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl <= next_ctrl;
      lockDly <= next_lockDly;
      deblkDly <= next_deblkDly;
      examT <= next_examT;
      manBlkT <= next_manBlkT;
      maxShots <= next_maxShots;
      maxPerHour <= next_maxPerHour;
      svc1 <= next_svc1;
      svc2 <= next_svc2;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      cmd <= next_cmd;
      irq <= |(next_irqStat & next_irqMask);
    end
  end

  // ---- blocking and manual close timers ----
  // hold block during delay
  always_comb begin
    next_blocked = recloseBlocked;
    next_blkTimer = blkTimer;
    if (blockCond) begin
      next_blocked = 1'b1;
      next_blkTimer = deblkDly;
    end else if (recloseBlocked) begin
      // leave only on a tick at zero, so the whole delay has passed
      if (msTick && blkTimer == 16'h0000) begin
        next_blocked = 1'b0;
      end else if (msTick) begin
        next_blkTimer = blkTimer - 16'h0001;
      end
    end
    next_manTimer = manTimer;
    if (manRise) begin
      next_manTimer = manBlkT;
    end else if (msTick && manTimer != 16'h0000) begin
      next_manTimer = manTimer - 16'h0001;
    end
  end

  // blocking flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      recloseBlocked <= 1'b0;
      blkTimer <= 16'h0000;
      manTimer <= 16'h0000;
    end else begin
      recloseBlocked <= next_blocked;
      blkTimer <= next_blkTimer;
      manTimer <= next_manTimer;
    end
  end

  // ---- sequencer ----
  logic [15:0] seqTimer, next_seqTimer; // exam or release ms
  logic next_close; // close pulse
  logic next_succ, next_fail; // outcome levels
  logic succPulse, failPulse; // outcome this cycle
  logic lockEnter; // entering lockout
  logic panelNow; // panel clear command
  logic clrReq; // any accepted clear
  logic startOk; // cycle may start
  assign panelNow = cmd[CMD_PANEL - 4];
  assign clrReq = panelNow | remClrRise | (ctrl[CTRL_DISEL] & pinClrRise);
  assign startOk = ctrl[CTRL_EN] && !recloseBlocked && (manTimer == 16'h0000)
    && !hourlyShotLimitExceeded && !serviceAlarmSecond;

  // next sequencer state
  always_comb begin
    next_state = state;
    next_shot = shot;
    next_seqTimer = seqTimer;
    next_close = 1'b0;
    succPulse = 1'b0;
    failPulse = 1'b0;
    lockEnter = 1'b0;
    if (shotAdvRise && shot != 8'hFF) begin
      next_shot = shot + 8'h01;
    end
    case (state)
      ST_READY: begin
        if (tripRise && startOk) begin
          next_state = ST_WAITOPEN;
        end
      end
      ST_WAITOPEN: begin
        if (abortAny) begin
          failPulse = 1'b1;
          next_state = ST_READY;
        end else if (!tripLvl && !cbClosed) begin
          if (shot >= maxShots) begin
            failPulse = 1'b1;
            lockEnter = 1'b1;
            next_state = ST_LOCKOUT;
          end else begin
            next_close = 1'b1;
            next_shot = shot + 8'h01;
            next_seqTimer = examT;
            next_state = ST_EXAMINE;
          end
        end
      end
      ST_EXAMINE: begin
        if (abortAny) begin
          failPulse = 1'b1;
          next_state = ST_READY;
        end else if (tripLvl) begin
          next_state = ST_WAITOPEN;
        end else if (!cbClosed) begin
          next_seqTimer = examT;
        end else if (msTick && seqTimer == 16'h0000) begin
          succPulse = 1'b1;
          next_state = ST_READY;
        end else if (msTick) begin
          next_seqTimer = seqTimer - 16'h0001;
        end
      end
      ST_LOCKOUT: begin
        if (clrReq && !extLock) begin
          next_seqTimer = lockDly;
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (msTick && seqTimer == 16'h0000) begin
          next_state = ST_READY;
        end else if (msTick) begin
          next_seqTimer = seqTimer - 16'h0001;
        end
      end
      default: next_state = ST_LOCKOUT;
    endcase
    if (extLock && state != ST_LOCKOUT) begin
      failPulse = (state == ST_WAITOPEN) || (state == ST_EXAMINE);
      succPulse = 1'b0;
      next_close = 1'b0;
      lockEnter = 1'b1;
      next_state = ST_LOCKOUT;
    end
    // restart shot count only on return to ready, keep advances made there
    if (next_state == ST_READY && state != ST_READY) begin
      next_shot = 8'h00;
    end
    next_succ = recloseSuccess;
    next_fail = recloseFailure;
    if (succPulse) begin
      next_succ = 1'b1;
      next_fail = 1'b0;
    end else if (failPulse) begin
      next_succ = 1'b0;
      next_fail = 1'b1;
    end else if (state == ST_READY && next_state == ST_WAITOPEN) begin
      next_succ = 1'b0;
      next_fail = 1'b0;
    end
  end

  // sequencer flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_READY;
      shot <= 8'h00;
      seqTimer <= 16'h0000;
      closeCommand <= 1'b0;
      recloseSuccess <= 1'b0;
      recloseFailure <= 1'b0;
      recloseRunning <= 1'b0;
      lockedOut <= 1'b0;
      panelLockoutCleared <= 1'b0;
    end else begin
      state <= next_state;
      shot <= next_shot;
      seqTimer <= next_seqTimer;
      closeCommand <= next_close;
      recloseSuccess <= next_succ;
      recloseFailure <= next_fail;
      recloseRunning <= (next_state == ST_WAITOPEN) || (next_state == ST_EXAMINE);
      lockedOut <= (next_state == ST_LOCKOUT) || (next_state == ST_RELEASE);
      panelLockoutCleared <= panelNow;
    end
  end

  // ---- statistics, service and hourly counters ----
  logic next_alm1, next_alm2, next_exceed; // alarm levels
  logic hourClr; // hourly counter clear
  assign hourClr = hourTick | cmd[CMD_HOUR - 4];

  // next counter values
  always_comb begin
    next_total = total;
    next_succCnt = succCnt;
    next_failCnt = failCnt;
    if (succPulse || failPulse) begin
      next_total = total + 16'h0001;
    end
    if (succPulse) begin
      next_succCnt = succCnt + 16'h0001;
    end
    if (failPulse) begin
      next_failCnt = failCnt + 16'h0001;
    end
    if (cmd[CMD_STAT - 4]) begin
      next_total = 16'h0000;
      next_succCnt = 16'h0000;
      next_failCnt = 16'h0000;
    end
    next_svcCnt = (next_close && svcCnt != 16'hFFFF) ? svcCnt + 16'h0001 : svcCnt;
    if (cmd[CMD_SVC - 4]) begin
      next_svcCnt = 16'h0000;
    end
    next_hourly = (next_close && hourly != 8'hFF) ? hourly + 8'h01 : hourly;
    if (hourClr) begin
      next_hourly = 8'h00;
    end
    next_alm1 = (svcCnt >= svc1);
    next_alm2 = (svcCnt >= svc2);
    next_exceed = (hourly > maxPerHour);
    events = 8'h00;
    events[EV_SUCC] = succPulse;
    events[EV_FAIL] = failPulse;
    events[EV_LOCK] = lockEnter;
    events[EV_PANEL] = panelLockoutCleared;
    events[EV_HOUR] = hourlyShotCounterCleared;
    events[EV_ALM1] = serviceAlarmFirst;
    events[EV_ALM2] = serviceAlarmSecond;
    events[EV_EXCEED] = hourlyShotLimitExceeded;
  end

  // counter flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      total <= 16'h0000;
      succCnt <= 16'h0000;
      failCnt <= 16'h0000;
      svcCnt <= 16'h0000;
      hourly <= 8'h00;
      serviceAlarmFirst <= 1'b0;
      serviceAlarmSecond <= 1'b0;
      hourlyShotLimitExceeded <= 1'b0;
      hourlyShotCounterCleared <= 1'b0;
    end else begin
      total <= next_total;
      succCnt <= next_succCnt;
      failCnt <= next_failCnt;
      svcCnt <= next_svcCnt;
      hourly <= next_hourly;
      serviceAlarmFirst <= next_alm1;
      serviceAlarmSecond <= next_alm2;
      hourlyShotLimitExceeded <= next_exceed;
      hourlyShotCounterCleared <= hourClr;
    end
  end
endmodule : reclose_supervision_control

// ==== tb/reclose_checker.sv ====
// Purpose: port-level properties of the reclose supervision block
// Assumes: MsCycles 10, delay registers at their reset values
// Notes: pin paths add a few synchroniser cycles
`timescale 1ns/100ps
module reclose_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic externalBlockInA,
  input wire logic externalBlockInB,
  input wire logic externalLockoutIn,
  input wire logic remoteLockoutClearIn,
  input wire logic [3:0] cycleAbortIn,
  input wire logic breakerClosedIn,
  input wire logic recloseRunning,
  input wire logic lockedOut,
  input wire logic recloseBlocked,
  input wire logic recloseSuccess,
  input wire logic recloseFailure,
  input wire logic hourlyShotCounterCleared
);
  localparam int DEBLOCK = 1000; // 100 ms at 10 cycles per ms
  logic [10:0] quiet; // cycles since a block input was last high
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // quiet-time counter, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) quiet <= '0;
    else if (externalBlockInA || externalBlockInB) quiet <= '0;
    else if (quiet != 11'h7FF) quiet <= quiet + 11'h001;
  end
  property p_outcome; !(recloseSuccess && recloseFailure); endproperty
  a_outcome: assert property (p_outcome) else $error("both outcomes set");
  property p_extlock; externalLockoutIn [*6] |-> lockedOut; endproperty
  a_extlock: assert property (p_extlock) else $error("lockout input ignored");
  property p_block; (externalBlockInA || externalBlockInB) [*6] |-> recloseBlocked; endproperty
  a_block: assert property (p_block) else $error("block input ignored");
  property p_deblock; $fell(recloseBlocked) |-> quiet >= DEBLOCK; endproperty
  a_deblock: assert property (p_deblock) else $error("deblocked too early");
  property p_lockhold; $rose(remoteLockoutClearIn) && lockedOut |=> lockedOut [*8]; endproperty
  a_lockhold: assert property (p_lockhold) else $error("lockout left early");
  property p_abort; (cycleAbortIn != 4'h0) [*6] |-> !recloseRunning; endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_success; $rose(recloseSuccess) |-> $past(breakerClosedIn, 8); endproperty
  a_success: assert property (p_success) else $error("success with breaker open");
  property p_hourpulse; hourlyShotCounterCleared |=> !hourlyShotCounterCleared; endproperty
  a_hourpulse: assert property (p_hourpulse) else $error("clear flag not a pulse");
  c_success: cover property ($rose(recloseSuccess));
  c_failure: cover property ($rose(recloseFailure));
  c_deblock: cover property ($fell(recloseBlocked));
endmodule : reclose_checker
bind reclose_supervision_control reclose_checker u_reclose_checker (.clk, .reset_n,
  .externalBlockInA, .externalBlockInB, .externalLockoutIn, .remoteLockoutClearIn,
  .cycleAbortIn, .breakerClosedIn, .recloseRunning, .lockedOut, .recloseBlocked,
  .recloseSuccess, .recloseFailure, .hourlyShotCounterCleared);

// ==== tb/breaker_model.sv ====
// Purpose: breaker model: opens on trip, closes on command
// Assumes: trip from the bench, close command from the block
// Notes: fixed three-cycle travel time each way
`timescale 1ns/100ps
module breaker_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tripIn,
  input wire logic closeCommand,
  output logic breakerClosed
);
  logic [2:0] travel; // position target delayed through the mechanism
  // trip wins over a close command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) travel <= 3'h7;
    else travel <= {travel[1:0], tripIn ? 1'b0 : (closeCommand | travel[0])};
  end
  assign breakerClosed = travel[2];
endmodule : breaker_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for reclose supervision
// Assumes: MsCycles 10, HourMs 50, zero-wait AHB slave
// Notes: waits are fixed by the documented delays plus sync slack
`timescale 1ns/100ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin failCount++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import reclose_pkg::*;
  int failCount = 0; // mismatches
  int totalChecks = 0; // comparisons made
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, externalBlockInA, externalBlockInB;
  logic externalShotAdvanceIn, externalLockoutIn, inputPinLockoutClearIn;
  logic remoteLockoutClearIn, tripIn, breakerClosedIn, manualCloseIn, closeCommand;
  logic recloseRunning, lockedOut, recloseBlocked, recloseSuccess, recloseFailure, irq;
  logic serviceAlarmFirst, serviceAlarmSecond, hourlyShotLimitExceeded;
  logic panelLockoutCleared, hourlyShotCounterCleared;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] cycleAbortIn;
  reclose_supervision_control #(.MsCycles(10), .HourMs(50)) u_reclose_supervision_control (
    .hready(hreadyout), .*);
  breaker_model u_breaker_model (.clk, .reset_n, .tripIn, .closeCommand,
    .breakerClosed(breakerClosedIn));
  always #5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one single-word transfer; hready sampled at each rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    if (!w) rd = hrdata;
  endtask : bus
  task automatic testDone;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : testDone
  task automatic tRegs;
    bus(0, A_CTRL, 0); `CHK(rd, 32'h00000001)
    bus(0, A_LOCKDLY, 0); `CHK(rd, 32'h00000064)
    bus(0, A_DEBLKDLY, 0); `CHK(rd, 32'h00000064)
    bus(0, 8'h3C, 0); `CHK(rd, 32'h00000000)
    `CHK(hresp, 1'b0)
  endtask : tRegs
  task automatic tSuccess;
    bus(1, A_IRQMASK, 32'h00000001);
    bus(1, A_LIMITS, 32'h00000002);
    tripIn <= 1'b1;
    cyc(10);
    tripIn <= 1'b0;
    cyc(10200);
    `CHK(recloseSuccess, 1'b1)
    `CHK(recloseFailure, 1'b0)
    `CHK(irq, 1'b1)
    bus(0, A_OUTCOME, 0); `CHK(rd, 32'h00000001)
    bus(0, A_IRQSTAT, 0); `CHK(rd[EV_EXCEED], 1'b1)
    bus(1, A_LIMITS, 32'h00000A02);
    bus(1, A_IRQSTAT, 32'h000000FF);
    cyc(2);
    `CHK(irq, 1'b0)
  endtask : tSuccess
  task automatic tCounters;
    bus(1, A_SVC1, 32'h00000001);
    cyc(2);
    `CHK(serviceAlarmFirst, 1'b1)
    `CHK(serviceAlarmSecond, 1'b0)
    bus(1, A_SVC2, 32'h00000001);
    cyc(2);
    `CHK(serviceAlarmSecond, 1'b1)
    bus(1, A_CTRL, 32'h000000E1);
    cyc(3);
    `CHK(serviceAlarmFirst, 1'b0)
    bus(0, A_SVCCNT, 0); `CHK(rd, 32'h00000000)
    bus(0, A_OUTCOME, 0); `CHK(rd, 32'h00000000)
    bus(0, A_TOTAL, 0); `CHK(rd, 32'h00000000)
    bus(0, A_IRQSTAT, 0); `CHK(rd[EV_HOUR], 1'b1)
    bus(0, A_SHOTS, 0); `CHK(rd[15:8], 8'h00)
    bus(1, A_SVC1, 32'h000003E8);
    bus(1, A_SVC2, 32'h000007D0);
    bus(1, A_IRQSTAT, 32'h000000FF);
    externalShotAdvanceIn <= 1'b1;
    cyc(2);
    externalShotAdvanceIn <= 1'b0;
    cyc(8);
    bus(0, A_SHOTS, 0); `CHK(rd[7:0], 8'h01)
  endtask : tCounters
  task automatic tBlock;
    for (int i = 0; i < 2; i++) begin
      {externalBlockInB, externalBlockInA} <= 2'(3'h1 << i);
      cyc(8);
      `CHK(recloseBlocked, 1'b1)
      {externalBlockInB, externalBlockInA} <= 2'h0;
      cyc(900);
      `CHK(recloseBlocked, 1'b1)
      cyc(300);
      `CHK(recloseBlocked, 1'b0)
    end
  endtask : tBlock
  task automatic tLock;
    externalLockoutIn <= 1'b1;
    cyc(8);
    externalLockoutIn <= 1'b0;
    inputPinLockoutClearIn <= 1'b1;
    cyc(2);
    inputPinLockoutClearIn <= 1'b0;
    cyc(1200);
    `CHK(lockedOut, 1'b1)
    bus(1, A_CTRL, 32'h00000003);
    for (int k = 0; k < 3; k++) begin
      externalLockoutIn <= 1'b1;
      cyc(8);
      `CHK(lockedOut, 1'b1)
      externalLockoutIn <= 1'b0;
      cyc(2);
      {remoteLockoutClearIn, inputPinLockoutClearIn} <= 2'(3'h1 << k);
      if (k == 2) bus(1, A_CTRL, 32'h00000013);
      cyc(2);
      {remoteLockoutClearIn, inputPinLockoutClearIn} <= 2'h0;
      cyc(900);
      `CHK(lockedOut, 1'b1)
      cyc(300);
      `CHK(lockedOut, 1'b0)
    end
    bus(0, A_IRQSTAT, 0); `CHK(rd[EV_PANEL], 1'b1)
    bus(1, A_IRQSTAT, 32'h000000FF);
  endtask : tLock
  task automatic tManualAbort;
    manualCloseIn <= 1'b1;
    cyc(2);
    manualCloseIn <= 1'b0;
    cyc(6);
    tripIn <= 1'b1;
    cyc(10);
    `CHK(recloseRunning, 1'b0)
    tripIn <= 1'b0;
    cyc(1200);
    for (int i = 0; i < 4; i++) begin
      tripIn <= 1'b1;
      cyc(8);
      `CHK(recloseRunning, 1'b1)
      cycleAbortIn <= 4'(5'h01 << i);
      cyc(8);
      `CHK(recloseFailure, 1'b1)
      `CHK(recloseRunning, 1'b0)
      tripIn <= 1'b0;
      cycleAbortIn <= 4'h0;
      cyc(4);
    end
  endtask : tManualAbort
  // about 19k cycles of tests; give them a wide margin
  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    testDone();
  end
  initial begin
    {clk, reset_n, hsel, hwrite, externalBlockInA, externalBlockInB} = 6'h00;
    {externalShotAdvanceIn, externalLockoutIn, inputPinLockoutClearIn} = 3'h0;
    {remoteLockoutClearIn, tripIn, manualCloseIn} = 3'h0;
    {haddr, hwdata, htrans, cycleAbortIn} = '0;
    hsize = 3'h2;
    cyc(8);
    reset_n <= 1'b1;
    cyc(1);
    tRegs();
    tSuccess();
    tCounters();
    tBlock();
    tLock();
    tManualAbort();
    testDone();
  end
endmodule : tb
